// ### include/cabd_map.vh
// constants for the alu and branch decode core
`ifndef CABD_MAP_VH
`define CABD_MAP_VH

`define CABD_RST_PC        16'h0000
`define CABD_RST_SP        16'h0100
`define CABD_RST_CCR       8'h00
`define CABD_VEC_BASE      16'hFFC0
`define CABD_BANK_BASE     16'h0100

`define CABD_CCR_C         0
`define CABD_CCR_V         1
`define CABD_CCR_Z         2
`define CABD_CCR_N         3
`define CABD_CCR_H         4

`define CABD_ALU_AND       4'h0
`define CABD_ALU_OR        4'h1
`define CABD_ALU_XOR       4'h2
`define CABD_ALU_AND_WORD      4'h4
`define CABD_ALU_ORW       4'h5
`define CABD_ALU_EXCLUSIVE_OR_WORD      4'h6
`define CABD_ALU_SUB       4'h8
`define CABD_ALU_DFA       4'h9
`define CABD_ALU_DFS       4'hA

`define CABD_OP_DFA        8'h84
`define CABD_OP_DFS        8'h94
`define CABD_OP_INCREMENT_WORD_SP    8'hC1
`define CABD_OP_DECREMENT_WORD_SP    8'hD1
`define CABD_OP_JMP_ACC    8'hE0
`define CABD_OP_JMP_EXT    8'h21
`define CABD_OP_CALL_EXT   8'h31
`define CABD_OP_SWAP_PC    8'hF4
`define CABD_OP_RET        8'h20
`define CABD_OP_RETURN_FROM_IRQ       8'h30

`define CABD_CYC_NOP       3'h1
`define CABD_CYC_SHORT     3'h2
`define CABD_CYC_3         3'h3
`define CABD_CYC_4         3'h4
`define CABD_CYC_5         3'h5
`define CABD_CYC_6         3'h6

`endif

// ### rtl/cabd_alu.v
// byte and word logic, compare subtraction and decimal fix unit
`timescale 1ns/100ps
`include "cabd_map.vh"
module cabd_alu (
  input  wire [3:0]  sel_in,
  input  wire [15:0] a_in,
  input  wire [15:0] b_in,
  input  wire        carry_in,
  input  wire        half_in,
  output reg  [15:0] res_out,
  output reg         n_out,
  output reg         z_out,
  output reg         v_out,
  output reg         c_out
);
  reg [8:0] diff;
  reg [8:0] sum;
  reg [7:0] adj;
  reg       big;

  always @* begin
    diff    = {1'b0, a_in[7:0]} - {1'b0, b_in[7:0]};
    big     = (a_in[7:0] > 8'h99);
    adj     = 8'h00;
    sum     = 9'h000;
    res_out = 16'h0000;
    v_out   = 1'b0;
    c_out   = carry_in;
    case (sel_in)
      `CABD_ALU_AND: res_out = {8'h00, a_in[7:0] & b_in[7:0]};
      `CABD_ALU_OR: res_out = {8'h00, a_in[7:0] | b_in[7:0]};
      `CABD_ALU_XOR: res_out = {8'h00, a_in[7:0] ^ b_in[7:0]};
      `CABD_ALU_AND_WORD: res_out = a_in & b_in;
      `CABD_ALU_ORW: res_out = a_in | b_in;
      `CABD_ALU_EXCLUSIVE_OR_WORD: res_out = a_in ^ b_in;
      `CABD_ALU_SUB: begin
        res_out = {8'h00, diff[7:0]};
        c_out   = diff[8];
        v_out   = (a_in[7] ^ b_in[7]) & (a_in[7] ^ diff[7]);
      end
      `CABD_ALU_DFA: begin
        adj[7:4] = (carry_in || big) ? 4'h6 : 4'h0;
        adj[3:0] = (half_in || a_in[3:0] > 4'h9) ? 4'h6 : 4'h0;
        sum      = {1'b0, a_in[7:0]} + {1'b0, adj};
        res_out  = {8'h00, sum[7:0]};
        c_out    = carry_in | big;
        v_out    = ~a_in[7] & sum[7];
      end
      `CABD_ALU_DFS: begin
        adj[7:4] = carry_in ? 4'h6 : 4'h0;
        adj[3:0] = half_in ? 4'h6 : 4'h0;
        sum      = {1'b0, a_in[7:0]} - {1'b0, adj};
        res_out  = {8'h00, sum[7:0]};
        v_out    = a_in[7] & ~sum[7];
      end
      default: res_out = 16'h0000;
    endcase
    if (sel_in[2]) begin
      n_out = res_out[15];
      z_out = (res_out == 16'h0000);
    end else begin
      n_out = res_out[7];
      z_out = (res_out[7:0] == 8'h00);
    end
  end
endmodule

// ### rtl/cabd_core.v
// alu, compare, branch and call decode/execute core
// What this block does
// - byte load to accumulator copies only low byte
// - operand bytes follow assembler operand order
// - byte and with temp, imm or memory
// - byte or, bank forms at 78 to 7F
// - byte xor, bank forms at 58 to 5F
// - word logic on full accumulator and temp
// - compare immediate sets flags, stores nothing
// - decimal fix after add or subtract
// - stack pointer step, flags untouched
// - branch on zero flag set or clear
// - branch on carry flag set or clear
// - branch on sign flag, flags unchanged
// - signed branches test v xor n
// - bit test branch on direct byte bit
// - absolute jump and jump through accumulator
// - vector call through eight entry table
// - absolute call saves return address
// - swap accumulator with program counter plus one
// - return pops program counter, flags kept
// - interrupt return restores flags and counter
// - relative displacement is signed eight bits
// - vector number is three opcode bits
// - only marked flags change per instruction
`timescale 1ns/100ps
`include "cabd_map.vh"
module cabd_core (
  input  wire        clk_in,
  input  wire        rst_b_in,
  output wire [15:0] prog_addr_out,
  input  wire [23:0] prog_code_in,
  output reg  [15:0] dm_addr_out,
  output reg         dm_rd_out,
  output reg         dm_wr_out,
  output reg  [7:0]  dm_wdata_out,
  input  wire [7:0]  dm_rdata_in,
  input  wire [4:0]  bank_ptr_in,
  input  wire [15:0] index_register_in,
  input  wire [15:0] extra_pointer_in,
  output wire [15:0] acc_out,
  output wire [15:0] temp_out,
  output wire [15:0] program_counter_out,
  output wire [15:0] stack_pointer_out,
  output wire [7:0]  ccr_out,
  output wire        instr_done_out
);
  localparam C_NOP  = 4'h0;
  localparam C_MOVB = 4'h1;
  localparam C_LOGB = 4'h2;
  localparam C_LOGW = 4'h3;
  localparam C_CMPI = 4'h4;
  localparam C_DEC  = 4'h5;
  localparam C_SPW  = 4'h6;
  localparam C_BR   = 4'h7;
  localparam C_BB   = 4'h8;
  localparam C_JMPA = 4'h9;
  localparam C_JMP  = 4'hA;
  localparam C_CALL = 4'hB;
  localparam C_XPC  = 4'hC;
  localparam C_RET  = 4'hD;
  localparam C_RETURN_FROM_IRQ = 4'hE;

  reg  [15:0] acc_reg;
  reg  [15:0] acc_next;
  reg  [15:0] temp_reg;
  reg  [15:0] temp_next;
  reg  [15:0] pc_reg;
  reg  [15:0] pc_next;
  reg  [15:0] sp_reg;
  reg  [15:0] sp_next;
  reg  [7:0]  ccr_reg;
  reg  [7:0]  ccr_next;
  reg  [2:0]  cyc_reg;
  reg         rd_prev_reg;
  reg  [7:0]  dat_reg [0:3];

  reg  [3:0]  cls;
  reg  [2:0]  len;
  reg  [1:0]  nbytes;
  reg  [2:0]  rd_n;
  reg  [2:0]  wr_n;
  reg  [15:0] rd_base;
  reg  [15:0] opnd_addr;
  reg  [7:0]  opnd_byte;
  reg  [3:0]  alu_sel;
  reg         take;
  reg  [2:0]  wcyc;

  wire [7:0]  opc = prog_code_in[23:16];
  wire [7:0]  b1  = prog_code_in[15:8];
  wire [7:0]  b2  = prog_code_in[7:0];
  wire        last = (cyc_reg == len - 3'h1);
  wire [15:0] ret_addr = pc_reg + {14'h0000, nbytes};
  wire [15:0] rel1 = {{8{b1[7]}}, b1};
  wire [15:0] rel2 = {{8{b2[7]}}, b2};
  wire [15:0] alu_res;
  wire        alu_n;
  wire        alu_z;
  wire        alu_v;
  wire        alu_c;
  wire        bit_sel = dat_reg[0][opc[2:0]];
  // only the @ep and bank forms carry the immediate as first operand byte
  wire [7:0]  cmp_imm = (opc[3] | (opc[1] & opc[0])) ? b1 : b2;

  // the program port returns three bytes at pc, so operands are at hand
  assign prog_addr_out       = pc_reg;
  assign acc_out             = acc_reg;
  assign temp_out            = temp_reg;
  assign program_counter_out = pc_reg;
  assign stack_pointer_out   = sp_reg;
  assign ccr_out             = ccr_reg;
  assign instr_done_out      = last;

  // operand address by low opcode nibble; first operand byte comes first
  always @* begin
    case (opc[3:0])
      4'h5: opnd_addr = {8'h00, b1};
      4'h6: opnd_addr = index_register_in + rel1;
      4'h7: opnd_addr = extra_pointer_in;
      default: opnd_addr = `CABD_BANK_BASE + {8'h00, bank_ptr_in, opc[2:0]};
    endcase
  end

  always @* begin
    cls     = C_NOP;
    len     = `CABD_CYC_NOP;
    nbytes  = 2'h1;
    rd_n    = 3'h0;
    wr_n    = 3'h0;
    rd_base = opnd_addr;
    alu_sel = `CABD_ALU_SUB;
    casez (opc)
      8'h0?, 8'h5?, 8'h6?, 8'h7?: begin
        if (opc[3:0] == 4'h3 && opc[7:4] != 4'h0) begin
          cls = C_LOGW;
          len = `CABD_CYC_3;
        end else if (opc[3:2] != 2'b00 ||
                     (opc[3:0] == 4'h2 && opc[7:4] != 4'h0)) begin
          cls = (opc[7:4] == 4'h0) ? C_MOVB : C_LOGB;
          case (opc[3:0])
            4'h2: len = `CABD_CYC_SHORT;
            4'h4: begin
              len    = `CABD_CYC_SHORT;
              nbytes = 2'h2;
            end
            4'h5: begin
              len    = `CABD_CYC_3;
              nbytes = 2'h2;
              rd_n   = 3'h1;
            end
            4'h6: begin
              len    = `CABD_CYC_4;
              nbytes = 2'h2;
              rd_n   = 3'h1;
            end
            default: begin
              len  = `CABD_CYC_3;
              rd_n = 3'h1;
            end
          endcase
        end
        case (opc[7:4])
          4'h6: alu_sel = (opc[3:0] == 4'h3) ? `CABD_ALU_AND_WORD : `CABD_ALU_AND;
          4'h7: alu_sel = (opc[3:0] == 4'h3) ? `CABD_ALU_ORW : `CABD_ALU_OR;
          default: alu_sel = (opc[3:0] == 4'h3) ? `CABD_ALU_EXCLUSIVE_OR_WORD :
                                                  `CABD_ALU_XOR;
        endcase
      end
      `CABD_OP_DFA, `CABD_OP_DFS: begin
        cls     = C_DEC;
        len     = `CABD_CYC_SHORT;
        alu_sel = opc[4] ? `CABD_ALU_DFS : `CABD_ALU_DFA;
      end
      8'h9?: begin
        if (opc[3] || opc[3:0] > 4'h4) begin
          cls    = C_CMPI;
          rd_n   = 3'h1;
          len    = (opc[3] | (opc[1] & opc[0])) ? `CABD_CYC_4 : `CABD_CYC_5;
          nbytes = (opc[3] | (opc[1] & opc[0])) ? 2'h2 : 2'h3;
        end
      end
      `CABD_OP_INCREMENT_WORD_SP, `CABD_OP_DECREMENT_WORD_SP: begin
        cls = C_SPW;
        len = `CABD_CYC_3;
      end
      8'b1111_1???: begin
        cls    = C_BR;
        len    = `CABD_CYC_3;
        nbytes = 2'h2;
      end
      8'hB?: begin
        cls     = C_BB;
        len     = `CABD_CYC_5;
        nbytes  = 2'h3;
        rd_n    = 3'h1;
        rd_base = {8'h00, b1};
      end
      `CABD_OP_JMP_ACC: begin
        cls = C_JMPA;
        len = `CABD_CYC_SHORT;
      end
      `CABD_OP_JMP_EXT: begin
        cls    = C_JMP;
        len    = `CABD_CYC_3;
        nbytes = 2'h3;
      end
      8'b1110_1???: begin
        cls     = C_CALL;
        len     = `CABD_CYC_6;
        rd_n    = 3'h2;
        wr_n    = 3'h2;
        rd_base = `CABD_VEC_BASE + {12'h000, opc[2:0], 1'b0};
      end
      `CABD_OP_CALL_EXT: begin
        cls    = C_CALL;
        len    = `CABD_CYC_6;
        nbytes = 2'h3;
        wr_n   = 3'h2;
      end
      `CABD_OP_SWAP_PC: begin
        cls = C_XPC;
        len = `CABD_CYC_3;
      end
      `CABD_OP_RET: begin
        cls     = C_RET;
        len     = `CABD_CYC_4;
        rd_n    = 3'h2;
        rd_base = sp_reg;
      end
      `CABD_OP_RETURN_FROM_IRQ: begin
        cls     = C_RETURN_FROM_IRQ;
        len     = `CABD_CYC_6;
        rd_n    = 3'h4;
        rd_base = sp_reg;
      end
      default: cls = C_NOP;
    endcase
  end

  // reads come first, then return-address writes, one access per cycle
  always @* begin
    wcyc         = cyc_reg - rd_n;
    dm_rd_out    = 1'b0;
    dm_wr_out    = 1'b0;
    dm_addr_out  = 16'h0000;
    dm_wdata_out = 8'h00;
    if (cyc_reg < rd_n) begin
      dm_rd_out   = 1'b1;
      dm_addr_out = rd_base + {13'h0000, cyc_reg};
    end else if (wcyc < wr_n) begin
      dm_wr_out    = 1'b1;
      dm_addr_out  = sp_reg - 16'h0002 + {13'h0000, wcyc};
      dm_wdata_out = (wcyc == 3'h0) ? ret_addr[15:8] : ret_addr[7:0];
    end
  end

  always @* begin
    case (cls)
      C_LOGB, C_MOVB: begin
        case (opc[3:0])
          4'h2: opnd_byte = temp_reg[7:0];
          4'h4: opnd_byte = b1;
          default: opnd_byte = dat_reg[0];
        endcase
      end
      default: opnd_byte = cmp_imm;
    endcase
  end

  cabd_alu u_alu (
    .sel_in   (alu_sel),
    .a_in     ((cls == C_LOGW || cls == C_DEC) ? acc_reg :
               (cls == C_CMPI) ? {8'h00, dat_reg[0]} :
               {8'h00, acc_reg[7:0]}),
    .b_in     ((cls == C_LOGW) ? temp_reg : {8'h00, opnd_byte}),
    .carry_in (ccr_reg[`CABD_CCR_C]),
    .half_in  (ccr_reg[`CABD_CCR_H]),
    .res_out  (alu_res),
    .n_out    (alu_n),
    .z_out    (alu_z),
    .v_out    (alu_v),
    .c_out    (alu_c)
  );

  always @* begin
    case (opc[2:1])
      2'h0: take = ccr_reg[`CABD_CCR_C];
      2'h1: take = ccr_reg[`CABD_CCR_N];
      2'h2: take = ccr_reg[`CABD_CCR_Z];
      default: take = ccr_reg[`CABD_CCR_V] ^ ccr_reg[`CABD_CCR_N];
    endcase
    take = take ^ ~opc[0];
  end

  // flags not touched by a class keep their value
  always @* begin
    acc_next  = acc_reg;
    temp_next = temp_reg;
    pc_next   = pc_reg;
    sp_next   = sp_reg;
    ccr_next  = ccr_reg;
    if (last) begin
      pc_next = ret_addr;
      case (cls)
        C_MOVB: begin
          temp_next = {temp_reg[15:8], acc_reg[7:0]};
          acc_next  = {acc_reg[15:8], opnd_byte};
          ccr_next[`CABD_CCR_N] = opnd_byte[7];
          ccr_next[`CABD_CCR_Z] = (opnd_byte == 8'h00);
        end
        C_LOGB, C_LOGW: begin
          acc_next = (cls == C_LOGW) ? alu_res :
                     {acc_reg[15:8], alu_res[7:0]};
          ccr_next[`CABD_CCR_N] = alu_n;
          ccr_next[`CABD_CCR_Z] = alu_z;
          ccr_next[`CABD_CCR_V] = 1'b0;
        end
        C_CMPI, C_DEC: begin
          if (cls == C_DEC)
            acc_next = {acc_reg[15:8], alu_res[7:0]};
          ccr_next[`CABD_CCR_N] = alu_n;
          ccr_next[`CABD_CCR_Z] = alu_z;
          ccr_next[`CABD_CCR_V] = alu_v;
          ccr_next[`CABD_CCR_C] = alu_c;
        end
        C_SPW: sp_next = opc[4] ? sp_reg - 16'h0001 : sp_reg + 16'h0001;
        C_BR: begin
          if (take)
            pc_next = ret_addr + rel1;
        end
        C_BB: begin
          ccr_next[`CABD_CCR_Z] = ~bit_sel;
          if (bit_sel == opc[3])
            pc_next = ret_addr + rel2;
        end
        C_JMPA: pc_next = acc_reg;
        C_JMP: pc_next = {b1, b2};
        C_CALL: begin
          sp_next = sp_reg - 16'h0002;
          pc_next = opc[6] ? {dat_reg[0], dat_reg[1]} : {b1, b2};
        end
        C_XPC: begin
          pc_next  = acc_reg;
          acc_next = pc_reg + 16'h0001;
        end
        C_RET: begin
          pc_next = {dat_reg[0], dat_reg[1]};
          sp_next = sp_reg + 16'h0002;
        end
        C_RETURN_FROM_IRQ: begin
          ccr_next = dat_reg[1];
          pc_next  = {dat_reg[2], dat_reg[3]};
          sp_next  = sp_reg + 16'h0004;
        end
        default: pc_next = ret_addr;
      endcase
    end
  end

  always @(posedge clk_in) begin
    if (!rst_b_in) begin
      acc_reg     <= 16'h0000;
      temp_reg    <= 16'h0000;
      pc_reg      <= `CABD_RST_PC;
      sp_reg      <= `CABD_RST_SP;
      ccr_reg     <= `CABD_RST_CCR;
      cyc_reg     <= 3'h0;
      rd_prev_reg <= 1'b0;
    end else begin
      acc_reg     <= acc_next;
      temp_reg    <= temp_next;
      pc_reg      <= pc_next;
      sp_reg      <= sp_next;
      ccr_reg     <= ccr_next;
      cyc_reg     <= last ? 3'h0 : cyc_reg + 3'h1;
      rd_prev_reg <= dm_rd_out & ~last;
    end
  end

  // read data arrives one cycle after the address; slot = read index
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dat
      always @(posedge clk_in) begin
        if (!rst_b_in)
          dat_reg[g] <= 8'h00;
        else if (rd_prev_reg && cyc_reg == g + 1)
          dat_reg[g] <= dm_rdata_in;
      end
    end
  endgenerate
endmodule

// ### verification/cabd_core_asserts.sv
// port assertions for the alu and branch core
`timescale 1ns/100ps
module cabd_core_asserts (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire [23:0] prog_code_in,
  input wire [15:0] prog_addr_out,
  input wire        dm_rd_out,
  input wire [15:0] dm_addr_out,
  input wire        dm_wr_out,
  input wire [7:0]  dm_wdata_out,
  input wire [15:0] acc_out,
  input wire [15:0] program_counter_out,
  input wire [15:0] stack_pointer_out,
  input wire [7:0]  ccr_out,
  input wire        instr_done_out
);
  wire [7:0]  op   = prog_code_in[23:16];
  wire [15:0] pc   = program_counter_out;
  wire [15:0] sp   = stack_pointer_out;
  wire        dn   = instr_done_out;
  wire        vn   = ccr_out[1] ^ ccr_out[3];
  wire [7:0]  cnd  = {vn, ~vn, ccr_out[2], ~ccr_out[2],
                      ccr_out[3], ~ccr_out[3], ccr_out[0], ~ccr_out[0]};
  wire [15:0] rel  = pc + 16'h0002 + {{8{prog_code_in[15]}},
                                      prog_code_in[15:8]};
  wire [15:0] tgt  = cnd[op[2:0]] ? rel : pc + 16'h0002;
  wire [15:0] ext  = prog_code_in[15:0];
  wire [15:0] pc1  = pc + 16'h0001;
  wire [15:0] ret  = pc + 16'h0003;
  wire [15:0] spn  = op[4] ? sp - 16'h0001 : sp + 16'h0001;
  wire [15:0] sp2  = sp + 16'h0002;
  wire [7:0]  ah   = acc_out[15:8];
  wire        c0   = ccr_out[0];
  wire        blog = (op[7:4] >= 4'h5) && (op[7:4] <= 4'h7) &&
                     (op[3:0] >= 4'h2) && (op[3:0] != 4'h3);
  reg         start_reg;
  // first cycle of an instruction: after reset or after a done cycle
  always @(posedge clk_in) begin
    if (!rst_b_in) start_reg <= 1'b1;
    else start_reg <= instr_done_out;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_COND_BR: assert property (dn && op[7:3] == 5'h1F |=>
    pc == $past(tgt) && $stable(ccr_out)) else $error("cond branch");
  AST_BR_LEN: assert property (start_reg && op[7:3] == 5'h1F |->
    !dn ##1 !dn ##1 dn) else $error("branch length");
  AST_JMP: assert property (dn && op == 8'h21 |=> pc == $past(ext))
    else $error("jump ext");
  AST_JMP_ACC: assert property (dn && op == 8'hE0 |=>
    pc == $past(acc_out)) else $error("jump acc");
  AST_SWAP: assert property (dn && op == 8'hF4 |=> pc == $past(acc_out)
    && acc_out == $past(pc1)) else $error("swap word");
  AST_SP_STEP: assert property (dn && (op == 8'hC1 || op == 8'hD1) |=>
    sp == $past(spn) && $stable(ccr_out)) else $error("sp step");
  AST_BYTE_LOGIC: assert property (dn && blog |=> !ccr_out[1] &&
    c0 == $past(c0) && ah == $past(ah)) else $error("byte logic");
  AST_CALL_PUSH: assert property (start_reg && op == 8'h31 |->
    (dm_wr_out && dm_addr_out == sp - 16'h0002 && dm_wdata_out == ret[15:8])
    ##1 (dm_wr_out && dm_wdata_out == ret[7:0])) else $error("call push");
  AST_CALL_LEN: assert property (start_reg && (op == 8'h31 ||
    op[7:3] == 5'h1D || op == 8'h30) |-> !dn [*5] ##1 dn)
    else $error("six cycle length");
  AST_RET: assert property (dn && op == 8'h20 |=> sp == $past(sp2) &&
    $stable(ccr_out)) else $error("return");
  AST_NOP: assert property (start_reg && op == 8'h44 |-> dn ##1
    pc == $past(pc1)) else $error("empty opcode");
  AST_CMP: assert property (dn && op[7:3] == 5'h13 |=> $stable(acc_out))
    else $error("compare stored");
  AST_FETCH: assert property (prog_addr_out == pc)
    else $error("fetch address");
  AST_RET_READ: assert property (start_reg && op == 8'h20 |->
    (dm_rd_out && dm_addr_out == sp) ##1
    (dm_rd_out && dm_addr_out == sp + 16'h0001)) else $error("return reads");
endmodule

// ### verification/cabd_core_bench.sv
// self-checking bench for the alu and branch core
`timescale 1ns/100ps
module cabd_core_bench;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  wire  [15:0] pa, dma, acc, tmp, pc, sp;
  wire  [23:0] code;
  wire  [7:0]  dwd, drd, ccr;
  wire         drs, dwr, done;
  int          bad_count = 0;
  int          checks = 0;
  logic [7:0]  a, op, b, c;
  logic [15:0] eacc, epc, esp;
  logic [3:0]  ef;
  logic [4:0]  bank = 5'h00;
  logic [15:0] ix = 16'h0040;
  logic [15:0] ep = 16'h0055;
  // acc byte, opcode, operands | acc, nzvc, pc, sp after two instructions
  logic [83:0] rows [0:38] = '{
    84'hF0643C00_0030_0_0004_0100, 84'hF0620000_0000_4_0003_0100,
    84'h81740200_0083_8_0004_0100, 84'h81780000_0081_8_0003_0100,
    84'h5A545A00_0000_4_0004_0100, 84'h5A5F0000_005D_0_0003_0100,
    84'hF0630000_0000_4_0003_0100, 84'hF0730000_00F0_0_0003_0100,
    84'hF0530000_00F0_0_0003_0100, 84'h01980100_0001_9_0004_0100,
    84'h019A0200_0001_4_0004_0100, 84'h01952010_0001_0_0005_0100,
    84'h0A840000_0010_0_0003_0100, 84'h12940000_0012_0_0003_0100,
    84'h01C10000_0001_0_0003_0101, 84'h01D10000_0001_0_0003_00FF,
    84'h00FD0500_0000_4_0009_0100, 84'h00FC0500_0000_4_0004_0100,
    84'h01F91000_0001_0_0004_0100, 84'h01F81000_0001_0_0014_0100,
    84'h80FBFE00_0080_8_0002_0100, 84'h80FAFE00_0080_8_0004_0100,
    84'h80FF0800_0080_8_000C_0100, 84'h80FE0800_0080_8_0004_0100,
    84'h01B20506_0001_0_0005_0100, 84'h01BA0506_0001_0_000B_0100,
    84'h01B10506_0001_4_000B_0100, 84'h01211234_0001_0_1234_0100,
    84'h55E00000_0055_0_0055_0100, 84'h40F40000_0003_0_0040_0100,
    84'h01440000_0001_0_0003_0100, 84'h01311234_0001_0_1234_00FE,
    84'hF0660500_0040_0_0004_0100, 84'h0176FE00_003F_0_0004_0100,
    84'h55570000_0000_4_0003_0100, 84'h3C650F00_000C_0_0004_0100,
    84'h01960242_0001_4_0005_0100, 84'h01976000_0001_9_0004_0100,
    84'h77052200_0022_0_0004_0100};

  always #10 clk_in = ~clk_in;

  // pointers held steady per test; the bank test moves the bank
  cabd_core cabd_core_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .prog_addr_out(pa), .prog_code_in(code), .dm_addr_out(dma),
    .dm_rd_out(drs), .dm_wr_out(dwr), .dm_wdata_out(dwd),
    .dm_rdata_in(drd), .bank_ptr_in(bank), .index_register_in(ix),
    .extra_pointer_in(ep), .acc_out(acc), .temp_out(tmp),
    .program_counter_out(pc), .stack_pointer_out(sp), .ccr_out(ccr),
    .instr_done_out(done));
  cabd_mem_model cabd_mem_model_inst (.clk_in(clk_in), .prog_addr_in(pa),
    .prog_code_out(code), .dm_addr_in(dma), .dm_rd_in(drs),
    .dm_wr_in(dwr), .dm_wdata_in(dwd), .dm_rdata_out(drd));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pm(input logic [15:0] ad, input logic [7:0] x, y, z);
    cabd_mem_model_inst.pmem[ad] = x;
    cabd_mem_model_inst.pmem[ad + 16'h0001] = y;
    cabd_mem_model_inst.pmem[ad + 16'h0002] = z;
  endtask
  task automatic reset;
    @(negedge clk_in) rst_b_in = 1'b0;
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
  endtask
  // counts done cycles; nops hold done high, so each cycle counts once
  task automatic run(input int n);
    int k;
    int g;
    k = 0;
    g = 0;
    while (k < n && g < 100) begin
      @(negedge clk_in);
      if (done === 1'b1) k++;
      g++;
    end
    if (k < n) chk(16'hDEAD, 16'h0000);
    @(negedge clk_in);
  endtask

  initial begin
    #200000;
    bad_count++;
    stop_test;
  end

  initial begin
    reset;
    chk(pc, 16'h0000);
    chk(sp, 16'h0100);
    chk({ccr, acc[7:0]}, 16'h0000);
    $display("reset test done");
    for (int i = 0; i < 39; i++) begin
      {a, op, b, c, eacc, ef, epc, esp} = rows[i];
      pm(16'h0000, 8'h04, a, op);
      pm(16'h0003, b, c, 8'h00);
      reset;
      run(2);
      chk(acc, eacc);
      chk({12'h000, ccr[3:0]}, {12'h000, ef});
      chk(pc, epc);
      chk(sp, esp);
      $display("row %0d done", i);
    end
    pm(16'h0000, 8'h21, 8'h12, 8'h30);
    pm(16'h1230, 8'h04, 8'h34, 8'hF4);
    pm(16'h0034, 8'h04, 8'h99, 8'h63);
    reset;
    run(5);
    chk(tmp, 16'h0033);
    chk(acc, 16'h0011);
    $display("temp copy test done");
    pm(16'h0000, 8'h31, 8'h12, 8'h34);
    pm(16'h1234, 8'h20, 8'h00, 8'h00);
    reset;
    run(1);
    chk(sp, 16'h00FE);
    chk({cabd_mem_model_inst.dmem[16'h00FE],
         cabd_mem_model_inst.dmem[16'h00FF]}, 16'h0003);
    run(1);
    chk(pc, 16'h0003);
    chk({ccr, sp[15:8]}, 16'h0001);
    $display("call return test done");
    pm(16'h0000, 8'hE9, 8'h00, 8'h00);
    pm(16'hABCD, 8'h30, 8'h00, 8'h00);
    cabd_mem_model_inst.dmem[16'hFFC2] = 8'hAB;
    cabd_mem_model_inst.dmem[16'hFFC3] = 8'hCD;
    cabd_mem_model_inst.dmem[16'h0100] = 8'h12;
    cabd_mem_model_inst.dmem[16'h0101] = 8'h56;
    reset;
    run(1);
    chk(pc, 16'hABCD);
    chk({cabd_mem_model_inst.dmem[16'h00FE],
         cabd_mem_model_inst.dmem[16'h00FF]}, 16'h0001);
    run(1);
    chk(pc, 16'h1256);
    chk({ccr, 8'h00}, 16'h0100);
    chk(sp, 16'h0102);
    $display("vector call test done");
    pm(16'h0000, 8'h04, 8'h70, 8'h9B);
    pm(16'h0003, 8'h04, 8'h94, 8'h00);
    reset;
    run(3);
    chk(acc, 16'h0010);
    chk({12'h000, ccr[3:0]}, 16'h0001);
    $display("decimal borrow test done");
    bank = 5'h02;
    pm(16'h0000, 8'h04, 8'hF0, 8'h79);
    reset;
    run(2);
    chk(acc, 16'h00F1);
    $display("bank test done");
    stop_test;
  end
endmodule

bind cabd_core cabd_core_asserts cabd_core_asserts_inst (.clk_in,
  .rst_b_in, .prog_code_in, .prog_addr_out, .dm_rd_out, .dm_addr_out,
  .dm_wr_out, .dm_wdata_out,
  .acc_out, .program_counter_out, .stack_pointer_out, .ccr_out,
  .instr_done_out);

// ### verification/cabd_mem_model.sv
// program and data memory beside the core
`timescale 1ns/100ps
module cabd_mem_model (
  input  wire        clk_in,
  input  wire [15:0] prog_addr_in,
  output wire [23:0] prog_code_out,
  input  wire [15:0] dm_addr_in,
  input  wire        dm_rd_in,
  input  wire        dm_wr_in,
  input  wire [7:0]  dm_wdata_in,
  output reg  [7:0]  dm_rdata_out
);
  reg [7:0] pmem [0:65535];
  reg [7:0] dmem [0:65535];
  initial begin
    dm_rdata_out = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      pmem[i] = 8'h00;
      dmem[i] = i[7:0];
    end
  end
  // three bytes at the fetch address, wrapping at the top
  assign prog_code_out = {pmem[prog_addr_in], pmem[prog_addr_in + 16'h0001],
                          pmem[prog_addr_in + 16'h0002]};
  // no wait states; a cycle without a read returns junk, not old data
  always @(posedge clk_in) begin
    if (dm_rd_in) dm_rdata_out <= dmem[dm_addr_in];
    else dm_rdata_out <= ~dm_rdata_out;
    if (dm_wr_in) dmem[dm_addr_in] <= dm_wdata_in;
  end
endmodule
